// ### design/usm_brg.sv
// bit-rate generator: one tick every div+1 enabled cycles.
// assumes: div is stable while en is high.
`timescale 1ns/100ps
`default_nettype none
module usm_brg import usm_pkg::*; #(
	parameter int DIV_W = DIV_WIDTH
) (
	// clock, reset and enable
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// rate port
	usm_brg_if.gen   brg
);
	logic [DIV_W-1:0] cnt_reg;

	if (DIV_W < 2 * REG_W) begin : g_chk
		$error("divider narrower than two registers");
	end

	// ----------------------------------------
	// down counter
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_reg <= '0;
		end else if (ce) begin
			if (!brg.en || cnt_reg == '0) begin
				cnt_reg <= brg.div;
			end else begin
				cnt_reg <= cnt_reg - 1'b1;
			end
		end
	end

	assign brg.tick = ce & brg.en & (cnt_reg == '0);
endmodule
`default_nettype wire

// ### design/usm_brg_if.sv
// carrier between the shift engine and the bit-rate generator.
// assumes: both ends run on the same clock.
`timescale 1ns/100ps
`default_nettype none
interface usm_brg_if #(parameter int DIV_W = 16);
	logic             en;
	logic [DIV_W-1:0] div;
	logic             tick;
	modport gen (input en, input div, output tick);
	modport use_ (output en, output div, input tick);
endinterface
`default_nettype wire

// ### design/usm_pkg.sv
// constants, field layout and types of the synchronous serial port.
// assumes: a 32-bit AXI4-Lite register bus and 8-bit registers.
package usm_pkg;
	// ----------------------------------------
	// widths
	// ----------------------------------------
	localparam int         REG_W     = 8;
	localparam int         DIV_WIDTH = 16;
	localparam int         ADDR_W    = 8;
	localparam logic [3:0] BITS_8    = 4'h8;
	localparam logic [3:0] BITS_9    = 4'h9;
	localparam logic [3:0] BIT_LAST  = 4'h1;
	// ----------------------------------------
	// register byte offsets
	// ----------------------------------------
	localparam logic [7:0] OFF_RSC = 8'h00;
	localparam logic [7:0] OFF_TXB = 8'h04;
	localparam logic [7:0] OFF_TSC = 8'h08;
	localparam logic [7:0] OFF_BC  = 8'h0C;
	localparam logic [7:0] OFF_DVH = 8'h10;
	localparam logic [7:0] OFF_DVL = 8'h14;
	localparam logic [7:0] OFF_RXB = 8'h18;
	localparam logic [7:0] OFF_PFR = 8'h1C;
	localparam logic [7:0] OFF_PER = 8'h20;
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int RSC_PORT_EN = 7;
	localparam int RSC_NINE    = 6;
	localparam int RSC_SINGLE  = 5;
	localparam int RSC_CONT    = 4;
	localparam int RSC_OVERRUN = 1;
	localparam int RSC_NINTH   = 0;
	localparam int TSC_CLK_SRC = 7;
	localparam int TSC_NINE    = 6;
	localparam int TSC_TX_EN   = 5;
	localparam int TSC_SYNC    = 4;
	localparam int TSC_HSPEED  = 2;
	localparam int TSC_SR_EMPT = 1;
	localparam int TSC_NINTH   = 0;
	localparam int BC_RX_IDLE  = 6;
	localparam int BC_POL      = 4;
	localparam int BC_WIDE     = 3;
	localparam int BC_WAKE     = 1;
	localparam int BC_AUTOBAUD = 0;
	localparam int PFR_RX_FLAG = 5;
	localparam int PFR_TX_FLAG = 4;
	// ----------------------------------------
	// bus answers and resets
	// ----------------------------------------
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
	localparam logic [7:0]  RST_BYTE    = 8'h00;
	localparam logic [15:0] RST_DIV     = 16'h0000;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_TX   = 3'b010,
		ST_RX   = 3'b100
	} usm_state_t;
endpackage

// ### design/usm_sync_port.sv
// synchronous master/slave serial port with AXI4-Lite registers.
// assumes: pins ck/dt resolved outside from the enables; ck and dt
// arrive asynchronous to aclk.
// Functional notes
// (R01) software slows rate 9/13 for break
// (R02) wake-up: two transitions, flag, then byte
// (R03) software may request auto-baud after break
// (R04) clock-source bit selects master operation
// (R05) half-duplex: transmit and receive exclude each other
// (R06) sync plus port enable claim clock/data pins
// (R07) master drives shift clock on clock line
// (R08) polarity bit sets clock idle level
// (R09) reload shift register right after last bit
// (R10) load takes one cycle, flag sets
// (R11) transmit flag clears only on buffer write
// (R12) shift-empty bit readable, no interrupt
// (R13) software setup order for master transmit
// (R14) ninth transmit bit sent as bit nine
// (R15) single or continuous enable starts reception
// (R16) data sampled on falling shift clock edge
// (R17) single takes one word, continuous governs
// (R18) word done sets flag, enable gates request
// (R19) software clears both enables before reception
// (R20) software reads status before buffer, clears errors
// (R21) clock-source clear selects slave, external clock
// (R22) slave runs purely from external clock
// (R23) wake-up bit suspends reception, awaits fall
// (R24) master rate from 8/16-bit divider
// (R25) lsb first, eight or nine bits
`timescale 1ns/100ps
`default_nettype none
module usm_sync_port import usm_pkg::*; (
	// clock, reset, enable
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        ce,
	// axi4-lite write
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// axi4-lite read
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// shift clock pin
	input  wire logic        ck_in,
	output logic             ck_out,
	output logic             ck_oe,
	// serial data pin
	input  wire logic        dt_in,
	output logic             dt_out,
	output logic             dt_oe,
	// requests
	output logic             rx_irq,
	output logic             tx_irq
);
	usm_state_t  state_reg;
	logic        port_en_reg, nine_rx_reg, single_reg, cont_reg;
	logic        overrun_reg, ninth_rx_reg, clk_src_reg, nine_tx_reg;
	logic        tx_en_reg, sync_reg, hspeed_reg, ninth_tx_reg;
	logic        pol_reg, wide_reg, wake_reg, autobaud_reg;
	logic        wake_seen_reg, txfull_reg, rxflag_reg;
	logic        tx_ie_reg, rx_ie_reg, phase_reg, ck_d_reg, dt_d_reg;
	logic [7:0]  div_hi_reg, div_lo_reg, txbuf_reg, rxbuf_reg;
	logic [8:0]  tsr_reg, rsr_reg, rsr_next;
	logic [3:0]  cnt_reg;
	logic [1:0]  ck_sync_reg, dt_sync_reg;
	logic        wr, rd, active, master, ck_i, dt_s, fall;
	logic        tx_go, rx_go, rx_on, tx_done, rx_done, tx_flag;
	logic        dt_fall, dt_rise, wake_ev;
	logic [15:0] base_div;
	logic [3:0]  nbits;

	usm_brg_if #(.DIV_W(DIV_WIDTH)) brg ();
	usm_brg #(.DIV_W(DIV_WIDTH)) u_brg (
		.aclk    (aclk),
		.aresetn (aresetn),
		.ce      (ce),
		.brg     (brg.gen)
	);

	// ----------------------------------------
	// bus handshake
	// ----------------------------------------
	assign awready = ce & awvalid & wvalid & ~bvalid;
	assign wready  = awready;
	assign arready = ce & ~rvalid;
	assign wr      = awready & wstrb[0];
	assign rd      = arvalid & arready;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp  <= RESP_OKAY;
		end else if (ce) begin
			if (awready) begin
				bvalid <= 1'b1;
				bresp  <= (awaddr > OFF_PER || awaddr[1:0] != 2'h0) ? RESP_SLVERR : RESP_OKAY;
			end else if (bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rresp  <= RESP_OKAY;
			rdata  <= '0;
		end else if (ce) begin
			if (rd) begin
				rvalid <= 1'b1;
				rresp  <= RESP_OKAY;
				rdata  <= '0;
				case (araddr)
				OFF_RSC: rdata[7:0] <= {port_en_reg, nine_rx_reg, single_reg, cont_reg,
					2'h0, overrun_reg, ninth_rx_reg};
				OFF_TXB: rdata[7:0] <= txbuf_reg;
				OFF_TSC: rdata[7:0] <= {clk_src_reg, nine_tx_reg, tx_en_reg, sync_reg,
					1'b0, hspeed_reg, state_reg != ST_TX, ninth_tx_reg}; // [R12]
				OFF_BC:  rdata[7:0] <= {1'b0, state_reg != ST_RX, 1'b0, pol_reg, wide_reg,
					1'b0, wake_reg, autobaud_reg};
				OFF_DVH: rdata[7:0] <= div_hi_reg;
				OFF_DVL: rdata[7:0] <= div_lo_reg;
				OFF_RXB: rdata[7:0] <= rxbuf_reg;
				OFF_PFR: rdata[7:0] <= {2'h0, rxflag_reg, tx_flag, 4'h0};
				OFF_PER: rdata[7:0] <= {2'h0, rx_ie_reg, tx_ie_reg, 4'h0};
				default: rresp <= RESP_SLVERR;
				endcase
			end else if (rready) begin
				rvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// configuration registers
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			{port_en_reg, nine_rx_reg, cont_reg, clk_src_reg, nine_tx_reg} <= 5'h00;
			{tx_en_reg, sync_reg, hspeed_reg, ninth_tx_reg} <= 4'h0;
			{pol_reg, wide_reg, autobaud_reg, tx_ie_reg, rx_ie_reg} <= 5'h00;
			{div_hi_reg, div_lo_reg} <= RST_DIV;
		end else if (ce && wr) begin
			case (awaddr)
			OFF_RSC: begin
				port_en_reg <= wdata[RSC_PORT_EN];
				nine_rx_reg <= wdata[RSC_NINE];
				cont_reg    <= wdata[RSC_CONT];
			end
			OFF_TSC: begin
				clk_src_reg  <= wdata[TSC_CLK_SRC];
				nine_tx_reg  <= wdata[TSC_NINE];
				tx_en_reg    <= wdata[TSC_TX_EN];
				sync_reg     <= wdata[TSC_SYNC];
				hspeed_reg   <= wdata[TSC_HSPEED];
				ninth_tx_reg <= wdata[TSC_NINTH];
			end
			OFF_BC: begin
				pol_reg      <= wdata[BC_POL];
				wide_reg     <= wdata[BC_WIDE];
				autobaud_reg <= wdata[BC_AUTOBAUD];
			end
			OFF_DVH: div_hi_reg <= wdata[7:0];
			OFF_DVL: div_lo_reg <= wdata[7:0];
			OFF_PER: begin
				rx_ie_reg <= wdata[PFR_RX_FLAG];
				tx_ie_reg <= wdata[PFR_TX_FLAG];
			end
			default: ;
			endcase
		end
	end

	// single enable: software sets, hardware drops after one word unless continuous is set
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			single_reg <= 1'b0;
		end else if (ce) begin
			if (wr && awaddr == OFF_RSC) begin
				single_reg <= wdata[RSC_SINGLE];
			end else if (rx_done && !cont_reg) begin
				single_reg <= 1'b0; // [R17]
			end
		end
	end

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ck_sync_reg <= 2'h0;
			dt_sync_reg <= 2'h0;
			ck_d_reg    <= 1'b0;
			dt_d_reg    <= 1'b0;
		end else if (ce) begin
			ck_sync_reg <= {ck_sync_reg[0], ck_in};
			dt_sync_reg <= {dt_sync_reg[0], dt_in};
			ck_d_reg    <= ck_i;
			dt_d_reg    <= dt_s;
		end
	end

	assign ck_i    = ck_sync_reg[1] ^ pol_reg;
	assign dt_s    = dt_sync_reg[1];
	assign dt_fall = ce & dt_d_reg & ~dt_s;
	assign dt_rise = ce & ~dt_d_reg & dt_s;

	// ----------------------------------------
	// shift clock
	// ----------------------------------------
	assign active   = port_en_reg & sync_reg; // [R06]
	assign master   = clk_src_reg; // [R04]
	// low-speed count (8-bit, or low 14 bits of the 16-bit) stretched by four, a trade for slower slaves
	assign base_div = wide_reg ? {div_hi_reg, div_lo_reg} : {8'h00, div_lo_reg};
	assign brg.div  = hspeed_reg ? base_div : {base_div[13:0], 2'h3}; // [R24]
	assign brg.en   = active & master & (state_reg != ST_IDLE);
	// slave edges come only from the pin, so no internal rate is needed
	assign fall = master ? brg.tick & phase_reg : ce & ~ck_i & ck_d_reg; // [R21] [R22]

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			phase_reg <= 1'b0;
		end else if (ce) begin
			if (state_reg == ST_IDLE || !master) begin
				phase_reg <= 1'b0;
			end else if (brg.tick) begin
				phase_reg <= ~phase_reg;
			end
		end
	end

	assign ck_oe  = active & master; // [R07]
	assign ck_out = phase_reg ^ pol_reg; // [R08]

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	assign nbits   = nine_tx_reg ? BITS_9 : BITS_8;
	assign rx_on   = single_reg | cont_reg; // [R15]
	assign tx_go   = ce & active & tx_en_reg & txfull_reg & ~wake_reg
		& (state_reg == ST_IDLE); // [R09]
	assign rx_go   = ce & active & rx_on & ~wake_reg & ~tx_go
		& (state_reg == ST_IDLE); // [R05] [R23]
	assign tx_done = fall & (state_reg == ST_TX) & (cnt_reg == BIT_LAST);
	assign rx_done = fall & (state_reg == ST_RX) & rx_on & (cnt_reg == BIT_LAST);
	assign rsr_next = {dt_s, rsr_reg[8:1]};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= ST_IDLE;
			cnt_reg   <= '0;
			tsr_reg   <= '0;
			rsr_reg   <= '0;
		end else if (ce) begin
			case (state_reg)
			ST_IDLE: begin
				if (tx_go) begin
					state_reg <= ST_TX;
					tsr_reg   <= {ninth_tx_reg, txbuf_reg}; // [R14] [R10]
					cnt_reg   <= nbits;
				end else if (rx_go) begin
					state_reg <= ST_RX;
					cnt_reg   <= nine_rx_reg ? BITS_9 : BITS_8;
				end
			end
			ST_TX: begin
				if (!active) begin
					state_reg <= ST_IDLE;
				end else if (fall) begin
					tsr_reg <= {1'b0, tsr_reg[8:1]}; // [R25]
					cnt_reg <= cnt_reg - 1'b1;
					if (tx_done) begin
						state_reg <= ST_IDLE;
					end
				end
			end
			ST_RX: begin
				if (!active || !rx_on) begin
					state_reg <= ST_IDLE;
				end else if (fall) begin
					rsr_reg <= rsr_next; // [R16]
					cnt_reg <= cnt_reg - 1'b1;
					if (rx_done) begin
						state_reg <= ST_IDLE;
					end
				end
			end
			default: state_reg <= ST_IDLE;
			endcase
		end
	end

	assign dt_oe  = active & (state_reg == ST_TX);
	assign dt_out = tsr_reg[0];

	// ----------------------------------------
	// transmit buffer and flag
	// ----------------------------------------
	// a write in the load cycle wins, so the new word is kept
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			txbuf_reg  <= RST_BYTE;
			txfull_reg <= 1'b0;
		end else if (ce) begin
			if (wr && awaddr == OFF_TXB) begin
				txbuf_reg  <= wdata[7:0];
				txfull_reg <= 1'b1; // [R11]
			end else if (tx_go) begin
				txfull_reg <= 1'b0; // [R10]
			end
		end
	end

	assign tx_flag = ~txfull_reg;
	assign tx_irq  = tx_flag & tx_ie_reg;

	// ----------------------------------------
	// receive buffer, flag, errors
	// ----------------------------------------
	assign wake_ev = wake_reg & ~wake_seen_reg & dt_fall;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rxbuf_reg    <= RST_BYTE;
			ninth_rx_reg <= 1'b0;
			rxflag_reg   <= 1'b0;
			overrun_reg  <= 1'b0;
		end else if (ce) begin
			if (rx_done) begin
				rxbuf_reg    <= nine_rx_reg ? rsr_next[7:0] : rsr_next[8:1]; // [R25]
				ninth_rx_reg <= nine_rx_reg & rsr_next[8];
			end
			// hardware set wins over the read that clears
			if (rx_done || wake_ev) begin
				rxflag_reg <= 1'b1; // [R18] [R02]
			end else if (rd && araddr == OFF_RXB) begin
				rxflag_reg <= 1'b0;
			end
			if (rx_done && rxflag_reg && !(rd && araddr == OFF_RXB)) begin
				overrun_reg <= 1'b1;
			end else if (wr && awaddr == OFF_RSC && !wdata[RSC_CONT]) begin
				overrun_reg <= 1'b0;
			end
		end
	end

	assign rx_irq = rxflag_reg & rx_ie_reg; // [R18]

	// ----------------------------------------
	// wake-up watch
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wake_reg      <= 1'b0;
			wake_seen_reg <= 1'b0;
		end else if (ce) begin
			if (wr && awaddr == OFF_BC && wdata[BC_WAKE]) begin
				wake_reg      <= 1'b1;
				wake_seen_reg <= 1'b0;
			end else if (wake_ev) begin
				wake_seen_reg <= 1'b1; // [R02]
			end else if (wake_seen_reg && dt_rise) begin
				wake_reg      <= 1'b0; // [R23]
				wake_seen_reg <= 1'b0;
			end else if (wr && awaddr == OFF_BC) begin
				wake_reg <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	sequence s_wake_fall;
		ce && wake_reg && !wake_seen_reg && dt_fall;
	endsequence
	sequence s_wake_done;
		rxflag_reg && wake_seen_reg;
	endsequence

	property p_load;
		@(posedge aclk) disable iff (!aresetn)
		tx_go && !(wr && awaddr == OFF_TXB) |=> state_reg == ST_TX && tx_flag;
	endproperty
	a_load: assert property (p_load) else $error("load did not set flag"); // [R10]

	property p_flag_hold;
		@(posedge aclk) disable iff (!aresetn)
		tx_flag && !(ce && wr && awaddr == OFF_TXB) |=> tx_flag;
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("transmit flag lost"); // [R11]

	property p_sr_empty;
		@(posedge aclk) disable iff (!aresetn)
		tx_done |=> state_reg != ST_TX;
	endproperty
	a_sr_empty: assert property (p_sr_empty) else $error("shifter not empty"); // [R12]

	property p_half;
		@(posedge aclk) disable iff (!aresetn)
		state_reg == ST_RX |-> !dt_oe;
	endproperty
	a_half: assert property (p_half) else $error("drive during receive"); // [R05]

	property p_idle_pol;
		@(posedge aclk) disable iff (!aresetn)
		state_reg == ST_IDLE && ce && !brg.tick ##1 state_reg == ST_IDLE |-> ck_out == pol_reg;
	endproperty
	a_idle_pol: assert property (p_idle_pol) else $error("idle clock level"); // [R08]

	property p_rx_flag;
		@(posedge aclk) disable iff (!aresetn)
		rx_done |=> rxflag_reg ##0 (rx_irq == rx_ie_reg);
	endproperty
	a_rx_flag: assert property (p_rx_flag) else $error("receive flag missing"); // [R18]

	property p_single;
		@(posedge aclk) disable iff (!aresetn)
		rx_done && !cont_reg && !(wr && awaddr == OFF_RSC) |=> !single_reg;
	endproperty
	a_single: assert property (p_single) else $error("single enable stuck"); // [R17]

	property p_sample;
		@(posedge aclk) disable iff (!aresetn)
		!fall |=> $stable(rsr_reg);
	endproperty
	a_sample: assert property (p_sample) else $error("sample off edge"); // [R16]

	property p_wake;
		@(posedge aclk) disable iff (!aresetn)
		s_wake_fall |=> s_wake_done;
	endproperty
	a_wake: assert property (p_wake) else $error("wake event lost"); // [R02]
endmodule
`default_nettype wire

// ### tb/tb_usm_sync_port.sv
// self-checking bench of the synchronous serial port.
// assumes: usm_slave_model on the far side, registers over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module tb_usm_sync_port import usm_pkg::*; ;
	typedef struct { logic p; logic nine; logic [8:0] w; } usm_txrow_t;
	logic        aclk    = 1'b0;
	logic        aresetn = 1'b0;
	logic        ce      = 1'b1;
	logic [7:0]  awaddr  = 8'h00;
	logic [7:0]  araddr  = 8'h00;
	logic [31:0] wdata   = 32'h0;
	logic [3:0]  wstrb   = 4'hF;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic        arvalid = 1'b0, rready = 1'b0, pol = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic        ck_out, ck_oe, dt_out, dt_oe, rx_irq, tx_irq, p_ck, p_cken, p_dt;
	logic [1:0]  bresp, rresp, rs;
	logic [31:0] rdata, rd;
	int          fail_count = 0;
	int          check_count = 0;
	wire         ck_line = ck_oe ? ck_out : (p_cken ? p_ck : pol);
	wire         dt_line = dt_oe ? dt_out : p_dt;
	usm_txrow_t  rows [4] = '{'{1'b0, 1'b0, 9'h0A5}, '{1'b1, 1'b0, 9'h03C},
		'{1'b0, 1'b1, 9'h196}, '{1'b1, 1'b1, 9'h00F}};
	logic [15:0] rst_tab [5] = '{16'h0000, 16'h0802, 16'h1000, 16'h1400, 16'h2000};
	initial begin
		forever #12.5 aclk = ~aclk;
	end
	usm_sync_port usm_sync_port_inst (.aclk(aclk), .aresetn(aresetn), .ce(ce),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .ck_in(ck_line), .ck_out(ck_out), .ck_oe(ck_oe),
		.dt_in(dt_line), .dt_out(dt_out), .dt_oe(dt_oe), .rx_irq(rx_irq),
		.tx_irq(tx_irq));
	usm_slave_model usm_slave_model_inst (.ck_line(ck_line), .dt_line(dt_line),
		.pol(pol), .ck_drv(p_ck), .ck_en(p_cken), .dt_drv(p_dt));
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin @(posedge aclk); n++; end
		while ((awready !== 1'b1 || wready !== 1'b1) && n < 100);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		do begin @(posedge aclk); n++; end while (bvalid !== 1'b1 && n < 200);
		if (bvalid !== 1'b1) begin
			fail_count++;
			$display("CHECK FAILED at %0t: write not answered", $time);
		end
		rs = bresp;
		bready <= 1'b0;
	endtask
	task automatic rdr(input logic [7:0] a);
		int n;
		n = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin @(posedge aclk); n++; end while (arready !== 1'b1 && n < 100);
		arvalid <= 1'b0;
		do begin @(posedge aclk); n++; end while (rvalid !== 1'b1 && n < 200);
		if (rvalid !== 1'b1) begin
			fail_count++;
			$display("CHECK FAILED at %0t: read not answered", $time);
		end
		rd = rdata;
		rs = rresp;
		rready <= 1'b0;
	endtask
	// w = 0 waits for the receive request, else for w captured words
	task automatic wait_ev(input int w);
		int n;
		n = 0;
		while (!(w == 0 ? rx_irq === 1'b1 : usm_slave_model_inst.words >= w) && n < 5000) begin
			@(posedge aclk);
			n++;
		end
		if (n >= 5000) begin
			fail_count++;
			$display("CHECK FAILED at %0t: wait limit reached", $time);
		end
	endtask
	task automatic stop_test;
		if (fail_count == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic do_reset;
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
	endtask
	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial begin
		do_reset;
		for (int i = 0; i < 4; i++) begin
			pol <= rows[i].p;
			wr(OFF_DVL, 32'h04);
			wr(OFF_BC, {27'h0, rows[i].p, 4'h0});
			wr(OFF_RSC, 32'h80);
			wr(OFF_PER, 32'h10);
			wr(OFF_TSC, {24'h0, 8'hB4 | {1'b0, rows[i].nine, 5'h0, rows[i].w[8]}});
			usm_slave_model_inst.arm(rows[i].nine ? 9 : 8, 9'h000);
			wr(OFF_TXB, {24'h0, rows[i].w[7:0]});
			wait_ev(1);
			chk(rows[i].nine ? usm_slave_model_inst.last : {1'b0, usm_slave_model_inst.last[7:0]}, rows[i].w, "tx word");
			rdr(OFF_TSC);
			chk(rd[TSC_SR_EMPT], 1'b1, "shift empty");
			chk(ck_out, rows[i].p, "clock idle");
			chk(tx_irq, 1'b1, "tx request");
		end
		wr(OFF_TSC, 32'hB4);
		usm_slave_model_inst.arm(8, 9'h000);
		wr(OFF_TXB, 32'h11);
		wr(OFF_TXB, 32'h22);
		chk(tx_irq, 1'b0, "flag cleared by write");
		wait_ev(1);
		chk(usm_slave_model_inst.last[7:0], 8'h11, "first word");
		wait_ev(2);
		chk(usm_slave_model_inst.last[7:0], 8'h22, "reloaded word");
		wr(OFF_PFR, 32'h0);
		rdr(OFF_PFR);
		chk(rd[PFR_TX_FLAG], 1'b1, "flag not cleared by software");
		do_reset;
		for (int k = 0; k < 5; k++) begin
			rdr(rst_tab[k][15:8]);
			chk(rd, {24'h0, rst_tab[k][7:0]}, "reset value");
		end
		chk(ck_oe, 1'b0, "no clock drive after reset");
		pol <= 1'b0;
		wr(OFF_DVL, 32'h04);
		wr(OFF_PER, 32'h20);
		wr(OFF_TSC, 32'h94);
		wr(OFF_RSC, 32'h80);
		usm_slave_model_inst.arm(8, 9'h05A);
		wr(OFF_RSC, 32'hA0);
		wait_ev(0);
		chk(rx_irq, 1'b1, "rx request");
		rdr(OFF_RSC);
		chk(rd, 32'h80, "single enable cleared");
		rdr(OFF_RXB);
		chk(rd, 32'h5A, "master rx word");
		chk(rx_irq, 1'b0, "rx flag cleared by read");
		wr(OFF_TSC, 32'h10);
		chk(ck_oe, 1'b0, "slave takes clock");
		wr(OFF_RSC, 32'h90);
		usm_slave_model_inst.arm(8, 9'h0C3);
		usm_slave_model_inst.clock_word(8);
		wait_ev(0);
		rdr(OFF_RXB);
		chk(rd, 32'hC3, "slave rx word");
		rdr(OFF_RSC);
		chk(rd, 32'h90, "continuous stays");
		wr(OFF_RSC, 32'h80);
		usm_slave_model_inst.arm(8, 9'h001);
		wr(OFF_DVL, 32'h0C);
		wr(OFF_BC, 32'h02);
		usm_slave_model_inst.arm(8, 9'h000);
		wait_ev(0);
		chk(rx_irq, 1'b1, "wake request");
		usm_slave_model_inst.arm(8, 9'h001);
		rdr(OFF_BC);
		for (int k = 0; k < 10 && rd[BC_WAKE] !== 1'b0; k++) rdr(OFF_BC);
		chk(rd[BC_WAKE], 1'b0, "wake ends on rise");
		wr(OFF_BC, 32'h01);
		rdr(OFF_BC);
		chk(rd[BC_AUTOBAUD], 1'b1, "auto-baud request kept");
		ce <= 1'b0;
		fork
			rdr(OFF_RXB);
			begin
				repeat (4) @(posedge aclk);
				chk(rvalid, 1'b0, "bus frozen while enable low");
				ce <= 1'b1;
			end
		join
		chk(rd, 32'hC3, "read after enable returns");
		wr(8'h24, 32'h0);
		chk(rs, RESP_SLVERR, "unmapped write");
		rdr(8'h24);
		chk(rs, RESP_SLVERR, "unmapped read response");
		chk(rd, 32'h0, "unmapped read data");
		stop_test;
	end
	initial begin
		#1000000;
		fail_count++;
		stop_test;
	end
endmodule
`default_nettype wire

// ### tb/usm_slave_model.sv
// behavioural slave on the shift clock and data lines.
// assumes: the bench resolves both lines and tells us the idle level.
`timescale 1ns/100ps
`default_nettype none
module usm_slave_model (
	// resolved lines
	input  wire logic ck_line,
	input  wire logic dt_line,
	input  wire logic pol,
	// our drive
	output logic      ck_drv,
	output logic      ck_en,
	output logic      dt_drv
);
	int         nbits    = 8;
	int         cnt      = 0;
	int         words    = 0;
	logic [8:0] word_out = 9'h000;
	logic [8:0] cap      = 9'h000;
	logic [8:0] last     = 9'h000;
	initial begin
		ck_drv = 1'b0;
		ck_en = 1'b0;
		dt_drv = 1'b1;
	end
	// new frame: stray edges seen before this are forgotten
	task automatic arm(input int n, input logic [8:0] w);
		nbits = n;
		word_out = w;
		cnt = 0;
		words = 0;
		dt_drv = w[0];
	endtask
	// active edge samples and presents, inactive edge ends the bit
	always @(ck_line) begin
		if (ck_line === ~pol) begin
			if (cnt < nbits) begin
				cap[cnt] = dt_line;
				dt_drv = word_out[cnt];
			end
		end else if (cnt < nbits) begin
			cnt++;
			if (cnt == nbits) begin
				words++;
				last = cap;
				cnt = 0;
				dt_drv = ~dt_drv; // inverted: no stale bit
			end
		end
	end
	// slave-mode frames; clock stands at idle between them
	task automatic clock_word(input int n);
		ck_drv = pol;
		ck_en = 1'b1;
		repeat (n) begin
			#100 ck_drv = ~pol;
			#100 ck_drv = pol;
		end
		#100 ck_en = 1'b0;
	endtask
endmodule
`default_nettype wire
